// ---- cw_pkg.sv ----
package cw_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ctrl_word_off = 8'h00;
   localparam logic [7:0] config_off = 8'h04;
   localparam logic [7:0] state_off = 8'h08;
   localparam logic [7:0] outputs_off = 8'h0C;
   localparam logic [7:0] estop_time_off = 8'h10;
   // ----------------------------------------------------------------
   // control word bit positions
   // ----------------------------------------------------------------
   localparam int bit_ramp_stop = 0;
   localparam int bit_coast_stop = 1;
   localparam int bit_quick_stop = 2;
   localparam int bit_op_enable = 3;
   localparam int bit_ramp_out_zero = 4;
   localparam int bit_ramp_hold = 5;
   localparam int bit_ramp_in_zero = 6;
   localparam int bit_fault_reset = 7;
   localparam int bit_fb_gate = 10;
   localparam int bit_location = 11;
   localparam int bit_specific_lo = 12;
   // config bits
   localparam int cfg_run_from_fb = 0;
   localparam int cfg_ramp_in_from_fb = 1;
   localparam int cfg_reset_from_fb = 2;
   localparam int cfg_loc_from_fb = 3;
   localparam logic [31:0] config_reset = 32'h0000000F;
   localparam logic [15:0] ctrl_word_reset = 16'h0000;
   localparam logic [15:0] estop_time_reset = 16'h0064;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      st_switch_on_inhibited,
      st_ready_to_switch_on,
      st_ready_to_operate,
      st_operation_enabled,
      st_ramp_stop_active,
      st_coast_stop_active,
      st_quick_stop_active,
      st_fault
   } drive_state_t;
   typedef struct packed {
      logic ramp_stop;
      logic coast_stop;
      logic quick_stop;
      logic op_enable;
      logic ramp_out_zero;
      logic ramp_hold;
      logic ramp_in_zero;
      logic fault_reset;
      logic fb_gate;
      logic location;
      logic [3:0] specific;
   } cw_fields_t;
   typedef struct packed {
      logic run_enable;
      logic ramp_out_enable;
      logic ramp_accel_enable;
      logic ramp_in_enable;
      logic location_two;
      logic fault_clear;
      logic coasting;
      logic [3:0] specific;
   } drive_cmd_t;
endpackage : cw_pkg

// ---- cw_field_split.sv ----
module cw_field_split (
   input wire logic [15:0] word,
   output cw_pkg::cw_fields_t fields
);
   // bits 8 and 9 are reserved and dropped here
   assign fields.ramp_stop = word[cw_pkg::bit_ramp_stop];
   assign fields.coast_stop = word[cw_pkg::bit_coast_stop];
   assign fields.quick_stop = word[cw_pkg::bit_quick_stop];
   assign fields.op_enable = word[cw_pkg::bit_op_enable];
   assign fields.ramp_out_zero = word[cw_pkg::bit_ramp_out_zero];
   assign fields.ramp_hold = word[cw_pkg::bit_ramp_hold];
   assign fields.ramp_in_zero = word[cw_pkg::bit_ramp_in_zero];
   assign fields.fault_reset = word[cw_pkg::bit_fault_reset];
   assign fields.fb_gate = word[cw_pkg::bit_fb_gate];
   assign fields.location = word[cw_pkg::bit_location];
   assign fields.specific = word[15:cw_pkg::bit_specific_lo];
endmodule : cw_field_split

// ---- drive_control_word_decoder.sv ----
// Chosen here: the AHB-Lite register port and the register offsets.
module drive_control_word_decoder (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic fault_in,
   input wire logic ext_run_enable,
   input wire logic speed_zero,
   output cw_pkg::drive_state_t drive_state,
   output cw_pkg::drive_cmd_t drive_cmd
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic [15:0] ctrl_word;
      logic [3:0] cfg;
      logic [15:0] estop_time;
      logic [15:0] estop_cnt;
      logic reset_prev;
      logic [1:0] fault_sync;
      logic [1:0] run_sync;
      logic [1:0] zero_sync;
      cw_pkg::drive_state_t st;
      cw_pkg::drive_cmd_t cmd;
   } state_t;

   state_t state_reg;
   state_t state_next;
   cw_pkg::cw_fields_t f;
   logic fault_s;
   logic run_s;
   logic zero_s;
   logic gate;
   logic run_ok;
   logic reset_edge;

   cw_field_split u_split (
      .word(state_reg.ctrl_word),
      .fields(f)
   );

   assign fault_s = state_reg.fault_sync[1];
   assign run_s = state_reg.run_sync[1];
   assign zero_s = state_reg.zero_sync[1];
   assign gate = f.fb_gate;
   // the bit always has to ask; a local run enable adds its own consent only when cfg_run_from_fb is clear
   assign run_ok = gate & f.op_enable & (state_reg.cfg[cw_pkg::cfg_run_from_fb] | run_s);
   assign reset_edge = gate & state_reg.cfg[cw_pkg::cfg_reset_from_fb] & f.fault_reset
      & ~state_reg.reset_prev;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = state_reg.rdata;
   assign drive_state = state_reg.st;
   assign drive_cmd = state_reg.cmd;

   always_comb begin
      state_next = state_reg;
      state_next.fault_sync = {state_reg.fault_sync[0], fault_in};
      state_next.run_sync = {state_reg.run_sync[0], ext_run_enable};
      state_next.zero_sync = {state_reg.zero_sync[0], speed_zero};
      state_next.reset_prev = f.fault_reset;
      // ----------------------------------------------------------------
      // bus slave: writes land in the data phase, zero wait
      // ----------------------------------------------------------------
      state_next.wr_pend = 1'b0;
      state_next.rd_pend = 1'b0;
      if (state_reg.wr_pend) begin
         if (state_reg.addr == cw_pkg::ctrl_word_off) begin
            state_next.ctrl_word = hwdata[15:0];
         end else if (state_reg.addr == cw_pkg::config_off) begin
            state_next.cfg = hwdata[3:0];
         end else if (state_reg.addr == cw_pkg::estop_time_off) begin
            state_next.estop_time = hwdata[15:0];
         end
      end
      if (hsel && hready && htrans[1]) begin
         state_next.addr = haddr[7:0];
         state_next.wr_pend = hwrite;
         state_next.rd_pend = ~hwrite;
         if (haddr[7:0] == cw_pkg::ctrl_word_off) begin
            state_next.rdata = {16'h0000, state_reg.ctrl_word & 16'hFCFF};
         end else if (haddr[7:0] == cw_pkg::config_off) begin
            state_next.rdata = {28'h0000000, state_reg.cfg};
         end else if (haddr[7:0] == cw_pkg::state_off) begin
            state_next.rdata = {29'h00000000, state_reg.st};
         end else if (haddr[7:0] == cw_pkg::outputs_off) begin
            state_next.rdata = {21'h000000, state_reg.cmd};
         end else if (haddr[7:0] == cw_pkg::estop_time_off) begin
            state_next.rdata = {16'h0000, state_reg.estop_time};
         end else begin
            state_next.rdata = 32'h00000000;
         end
      end
      // ----------------------------------------------------------------
      // drive state machine
      // ----------------------------------------------------------------
      // interlocks bypass the gate so the master can always stop
      if (fault_s && state_reg.st != cw_pkg::st_fault) begin
         state_next.st = cw_pkg::st_fault;
      end else if (!f.coast_stop && state_reg.st != cw_pkg::st_switch_on_inhibited
            && state_reg.st != cw_pkg::st_fault && state_reg.st != cw_pkg::st_coast_stop_active) begin
         state_next.st = cw_pkg::st_coast_stop_active;
      end else begin
         case (state_reg.st)
            cw_pkg::st_fault: begin
               if (reset_edge && !fault_s) begin
                  state_next.st = cw_pkg::st_switch_on_inhibited;
               end
            end
            cw_pkg::st_coast_stop_active: begin
               if (zero_s) begin
                  state_next.st = cw_pkg::st_switch_on_inhibited;
               end
            end
            cw_pkg::st_quick_stop_active: begin
               if (zero_s || state_reg.estop_cnt == 16'h0000) begin
                  state_next.st = cw_pkg::st_switch_on_inhibited;
               end else begin
                  state_next.estop_cnt = state_reg.estop_cnt - 16'h0001;
               end
            end
            cw_pkg::st_switch_on_inhibited: begin
               if (!f.ramp_stop && f.coast_stop && f.quick_stop) begin
                  state_next.st = cw_pkg::st_ready_to_switch_on;
               end
            end
            cw_pkg::st_ramp_stop_active: begin
               if (!f.quick_stop) begin
                  state_next.st = cw_pkg::st_quick_stop_active;
                  state_next.estop_cnt = state_reg.estop_time;
               end else if (zero_s) begin
                  state_next.st = cw_pkg::st_ready_to_switch_on;
               end
            end
            default: begin
               if (!f.quick_stop) begin
                  state_next.st = cw_pkg::st_quick_stop_active;
                  state_next.estop_cnt = state_reg.estop_time;
               end else if (!f.ramp_stop) begin
                  if (state_reg.st == cw_pkg::st_ready_to_switch_on) begin
                     state_next.st = cw_pkg::st_ready_to_switch_on;
                  end else begin
                     state_next.st = cw_pkg::st_ramp_stop_active;
                  end
               end else if (state_reg.st == cw_pkg::st_ready_to_switch_on) begin
                  state_next.st = cw_pkg::st_ready_to_operate;
               end else if (state_reg.st == cw_pkg::st_ready_to_operate) begin
                  if (run_ok) begin
                     state_next.st = cw_pkg::st_operation_enabled;
                  end
               end else if (!run_ok) begin
                  state_next.st = cw_pkg::st_ready_to_operate;
               end
            end
         endcase
      end
      // ----------------------------------------------------------------
      // command outputs
      // ----------------------------------------------------------------
      state_next.cmd.run_enable = (state_next.st == cw_pkg::st_operation_enabled);
      state_next.cmd.ramp_out_enable = gate & f.ramp_out_zero;
      state_next.cmd.ramp_accel_enable = gate & f.ramp_hold;
      // when not fieldbus sourced, the input is left enabled for the drive's own source
      state_next.cmd.ramp_in_enable = state_reg.cfg[cw_pkg::cfg_ramp_in_from_fb] ?
         (gate & f.ramp_in_zero) : 1'b1;
      if (gate && state_reg.cfg[cw_pkg::cfg_loc_from_fb]) begin
         state_next.cmd.location_two = f.location;
      end
      state_next.cmd.fault_clear = reset_edge;
      state_next.cmd.coasting = (state_next.st == cw_pkg::st_coast_stop_active);
      state_next.cmd.specific = gate ? f.specific : state_reg.cmd.specific;
      if (!gate) begin
         state_next.cmd.run_enable = state_next.cmd.run_enable & ~state_reg.cfg[cw_pkg::cfg_run_from_fb];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= '{wr_pend: 1'b0, rd_pend: 1'b0, addr: 8'h00, rdata: 32'h00000000,
            ctrl_word: cw_pkg::ctrl_word_reset, cfg: cw_pkg::config_reset[3:0],
            estop_time: cw_pkg::estop_time_reset, estop_cnt: 16'h0000, reset_prev: 1'b0,
            fault_sync: 2'h0, run_sync: 2'h0, zero_sync: 2'h0,
            st: cw_pkg::st_switch_on_inhibited, cmd: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_coast;
      @(posedge hclk) disable iff (!hresetn)
      (!f.coast_stop && !fault_s && state_reg.st == cw_pkg::st_operation_enabled)
         |=> state_reg.st == cw_pkg::st_coast_stop_active;
   endproperty
   a_coast: assert property (p_coast) else $error("coast stop not taken");

   property p_quick;
      @(posedge hclk) disable iff (!hresetn)
      (f.coast_stop && !f.quick_stop && !fault_s && state_reg.st == cw_pkg::st_operation_enabled)
         |=> state_reg.st == cw_pkg::st_quick_stop_active;
   endproperty
   a_quick: assert property (p_quick) else $error("quick stop not taken");

   property p_ramp_stop;
      @(posedge hclk) disable iff (!hresetn)
      (f.coast_stop && f.quick_stop && !f.ramp_stop && !fault_s
         && state_reg.st == cw_pkg::st_operation_enabled) |=> state_reg.st == cw_pkg::st_ramp_stop_active;
   endproperty
   a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop not taken");

   property p_enable;
      @(posedge hclk) disable iff (!hresetn)
      (f.coast_stop && f.quick_stop && f.ramp_stop && run_ok && !fault_s
         && state_reg.st == cw_pkg::st_ready_to_operate) |=> state_reg.st == cw_pkg::st_operation_enabled;
   endproperty
   a_enable: assert property (p_enable) else $error("operation not enabled");

   property p_inhibit;
      @(posedge hclk) disable iff (!hresetn)
      (f.coast_stop && f.quick_stop && f.ramp_stop && !run_ok && !fault_s
         && state_reg.st == cw_pkg::st_operation_enabled) |=> state_reg.st == cw_pkg::st_ready_to_operate;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("operation not inhibited");

   property p_out_zero;
      @(posedge hclk) disable iff (!hresetn)
      !f.ramp_out_zero |=> !drive_cmd.ramp_out_enable;
   endproperty
   a_out_zero: assert property (p_out_zero) else $error("ramp output not forced");

   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      !gate |=> !drive_cmd.ramp_accel_enable && $stable(drive_cmd.specific);
   endproperty
   a_hold: assert property (p_hold) else $error("gate closed but command passed");

   sequence s_reset_rise;
      state_reg.st == cw_pkg::st_fault && reset_edge && !fault_s;
   endsequence
   property p_reset;
      @(posedge hclk) disable iff (!hresetn)
      s_reset_rise |=> drive_cmd.fault_clear && state_reg.st == cw_pkg::st_switch_on_inhibited;
   endproperty
   a_reset: assert property (p_reset) else $error("fault reset edge lost");

   property p_accel;
      @(posedge hclk) disable iff (!hresetn)
      !f.ramp_hold |=> !drive_cmd.ramp_accel_enable;
   endproperty
   a_accel: assert property (p_accel) else $error("ramp not held");

   property p_ramp_in;
      @(posedge hclk) disable iff (!hresetn)
      state_reg.cfg[cw_pkg::cfg_ramp_in_from_fb] && !f.ramp_in_zero |=> !drive_cmd.ramp_in_enable;
   endproperty
   a_ramp_in: assert property (p_ramp_in) else $error("ramp input not forced");

   property p_location;
      @(posedge hclk) disable iff (!hresetn)
      gate && state_reg.cfg[cw_pkg::cfg_loc_from_fb] |=> drive_cmd.location_two == $past(f.location);
   endproperty
   a_location: assert property (p_location) else $error("location select not passed");

   property p_specific;
      @(posedge hclk) disable iff (!hresetn)
      gate |=> drive_cmd.specific == $past(f.specific);
   endproperty
   a_specific: assert property (p_specific) else $error("specific bits altered");

   sequence s_coast_done;
      state_reg.st == cw_pkg::st_coast_stop_active && zero_s && !fault_s;
   endsequence
   property p_coast_end;
      @(posedge hclk) disable iff (!hresetn)
      s_coast_done |=> state_reg.st == cw_pkg::st_switch_on_inhibited;
   endproperty
   a_coast_end: assert property (p_coast_end) else $error("coast stop did not end");

   property p_read_mask;
      @(posedge hclk) disable iff (!hresetn)
      hsel && hready && htrans[1] && !hwrite && haddr[7:0] == cw_pkg::ctrl_word_off |=> hrdata[9:8] == 2'b00;
   endproperty
   a_read_mask: assert property (p_read_mask) else $error("reserved bits read back");
endmodule : drive_control_word_decoder

// ---- fieldbus_master_model.sv ----
module fieldbus_master_model (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
   end
   // ----------------------------------------------------------------
   // one single word transfer, entered just after a rising edge
   // ----------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, addr};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      // released lines flip so a stale value never looks valid
      haddr <= ~{24'h000000, addr};
      hwdata <= data;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hwdata <= ~data;
   endtask : xfer
endmodule : fieldbus_master_model

// ---- drive_control_word_decoder_tb.sv ----
module drive_control_word_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fault_in, ext_run_enable, speed_zero;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] w;
   cw_pkg::drive_state_t drive_state;
   cw_pkg::drive_cmd_t drive_cmd;
   cw_pkg::drive_state_t es;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   localparam logic [31:0] quick_time = 32'h00000005;
   initial hclk = 1'b0;
   always #5 hclk = ~hclk;
   drive_control_word_decoder u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in),
      .ext_run_enable(ext_run_enable), .speed_zero(speed_zero), .drive_state(drive_state),
      .drive_cmd(drive_cmd));
   fieldbus_master_model u_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_master.xfer(1'b1, a, d, rd);
   endtask : wr
   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      u_master.xfer(1'b0, a, 32'h00000000, rd);
      chk(name, rd, exp);
   endtask : rdchk
   task automatic wait_st(input cw_pkg::drive_state_t st, input int limit);
      int n;
      n = 0;
      while (drive_state !== st && n < limit) begin
         @(posedge hclk);
         n++;
      end
      chk("drive_state", {29'h0, drive_state}, {29'h0, st});
   endtask : wait_st
   task automatic step(input logic [15:0] word, input cw_pkg::drive_state_t st);
      wr(cw_pkg::ctrl_word_off, {16'h0000, word});
      wait_st(st, 40);
   endtask : step
   // expected decode with gate open and every source on the fieldbus
   function automatic logic [4:0] exp_cmd(input logic [15:0] word, input cw_pkg::drive_state_t st);
      return {st == cw_pkg::st_operation_enabled, word[4], word[5], word[6], word[11]};
   endfunction : exp_cmd
   // settled state with both emergency stops released, no fault and standstill reported
   function automatic cw_pkg::drive_state_t exp_state(input cw_pkg::drive_state_t s, input logic [15:0] word);
      cw_pkg::drive_state_t n;
      n = s;
      for (int k = 0; k < 4; k++) begin
         case (n)
            cw_pkg::st_switch_on_inhibited: n = word[0] ? n : cw_pkg::st_ready_to_switch_on;
            cw_pkg::st_ready_to_switch_on: n = word[0] ? cw_pkg::st_ready_to_operate : n;
            cw_pkg::st_ramp_stop_active: n = cw_pkg::st_ready_to_switch_on;
            default: begin
               if (!word[0]) begin
                  n = cw_pkg::st_ramp_stop_active;
               end else begin
                  n = word[3] ? cw_pkg::st_operation_enabled : cw_pkg::st_ready_to_operate;
               end
            end
         endcase
      end
      return n;
   endfunction : exp_state
   task automatic cmd_chk(input logic [15:0] word, input cw_pkg::drive_state_t st);
      logic [4:0] e;
      e = exp_cmd(word, st);
      chk("coasting", {31'h0, drive_cmd.coasting}, 32'h00000000);
      chk("fault_clear", {31'h0, drive_cmd.fault_clear}, 32'h00000000);
      chk("run_enable", {31'h0, drive_cmd.run_enable}, {31'h0, e[4]});
      chk("ramp_out_enable", {31'h0, drive_cmd.ramp_out_enable}, {31'h0, e[3]});
      chk("ramp_accel_enable", {31'h0, drive_cmd.ramp_accel_enable}, {31'h0, e[2]});
      chk("ramp_in_enable", {31'h0, drive_cmd.ramp_in_enable}, {31'h0, e[1]});
      chk("location_two", {31'h0, drive_cmd.location_two}, {31'h0, e[0]});
      chk("specific", {28'h0, drive_cmd.specific}, {28'h0, word[15:12]});
   endtask : cmd_chk
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      fault_in = 1'b0;
      ext_run_enable = 1'b1;
      speed_zero = 1'b0;
      void'($urandom(98101));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk("ctrl_word", cw_pkg::ctrl_word_off, {16'h0000, cw_pkg::ctrl_word_reset});
      rdchk("config", cw_pkg::config_off, cw_pkg::config_reset);
      rdchk("state", cw_pkg::state_off, 32'h00000000);
      rdchk("outputs", cw_pkg::outputs_off, 32'h00000000);
      rdchk("estop_time", cw_pkg::estop_time_off, {16'h0000, cw_pkg::estop_time_reset});
      wr(8'h14, 32'hFFFFFFFF);
      rdchk("unmapped", 8'h14, 32'h00000000);
      chk("hresp", {31'h0, hresp}, 32'h00000000);
      $display("test reset and map done");
      wr(cw_pkg::estop_time_off, quick_time);
      step(16'hA476, cw_pkg::st_ready_to_switch_on);
      step(16'hA477, cw_pkg::st_ready_to_operate);
      step(16'hA47F, cw_pkg::st_operation_enabled);
      step(16'hA477, cw_pkg::st_ready_to_operate);
      step(16'hA47F, cw_pkg::st_operation_enabled);
      step(16'hA47E, cw_pkg::st_ramp_stop_active);
      speed_zero <= 1'b1;
      wait_st(cw_pkg::st_ready_to_switch_on, 20);
      speed_zero <= 1'b0;
      step(16'hA477, cw_pkg::st_ready_to_operate);
      step(16'hA47F, cw_pkg::st_operation_enabled);
      step(16'hA47B, cw_pkg::st_quick_stop_active);
      wait_st(cw_pkg::st_switch_on_inhibited, int'(quick_time) + 8);
      $display("test stop walk done");
      step(16'hA476, cw_pkg::st_ready_to_switch_on);
      step(16'hA477, cw_pkg::st_ready_to_operate);
      step(16'hA47F, cw_pkg::st_operation_enabled);
      step(16'h507D, cw_pkg::st_coast_stop_active);
      chk("coasting", {31'h0, drive_cmd.coasting}, 32'h00000001);
      chk("gated ramp_out", {31'h0, drive_cmd.ramp_out_enable}, 32'h00000000);
      chk("gated run", {31'h0, drive_cmd.run_enable}, 32'h00000000);
      chk("gated specific", {28'h0, drive_cmd.specific}, 32'h0000000A);
      speed_zero <= 1'b1;
      wait_st(cw_pkg::st_switch_on_inhibited, 20);
      speed_zero <= 1'b0;
      $display("test gate closed done");
      fault_in <= 1'b1;
      wait_st(cw_pkg::st_fault, 10);
      fault_in <= 1'b0;
      wr(cw_pkg::ctrl_word_off, 32'h00000474);
      repeat (4) @(posedge hclk);
      chk("fault held", {29'h0, drive_state}, {29'h0, cw_pkg::st_fault});
      wr(cw_pkg::ctrl_word_off, 32'h000004F4);
      for (int n = 0; n < 10 && drive_cmd.fault_clear !== 1'b1; n++) @(posedge hclk);
      chk("fault_clear", {31'h0, drive_cmd.fault_clear}, 32'h00000001);
      wait_st(cw_pkg::st_switch_on_inhibited, 10);
      $display("test fault reset done");
      wr(cw_pkg::config_off, 32'h00000000);
      wr(cw_pkg::ctrl_word_off, 32'h00000430);
      repeat (3) @(posedge hclk);
      chk("local ramp_in", {31'h0, drive_cmd.ramp_in_enable}, 32'h00000001);
      wr(cw_pkg::config_off, 32'h0000000F);
      repeat (3) @(posedge hclk);
      chk("fb ramp_in", {31'h0, drive_cmd.ramp_in_enable}, 32'h00000000);
      $display("test sources done");
      // stops held off, fault reset low and standstill reported so every ramp stop settles
      speed_zero <= 1'b1;
      es = cw_pkg::st_switch_on_inhibited;
      for (int i = 0; i < 40; i++) begin
         w = 16'($urandom());
         w[10] = 1'b1;
         w[2:1] = 2'b11;
         w[7] = 1'b0;
         wr(cw_pkg::ctrl_word_off, {16'h0000, w});
         es = exp_state(es, w);
         rdchk("ctrl_word", cw_pkg::ctrl_word_off, {16'h0000, w & 16'hFCFF});
         repeat (4) @(posedge hclk);
         chk("drive_state", {29'h0, drive_state}, {29'h0, es});
         cmd_chk(w, es);
      end
      $display("test random words done");
      complete_run();
   end
endmodule : drive_control_word_decoder_tb
